// ### sdc_config.sv
`timescale 1ns/1ps
module sdc_config (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Parallel programming pins
  input  wire logic                          parallel_load_strobe,
  input  wire logic [sdc_pkg::M_WIDTH-1:0]   feedback_div_in,
  input  wire logic [sdc_pkg::N_WIDTH-1:0]   output_div_in,
  // Serial programming pins (sampled edges)
  input  wire logic                          ser_clock,
  input  wire logic                          ser_data,
  input  wire logic                          ser_load,
  // Clocking controls
  input  wire logic                          master_clear,
  input  wire logic                          ref_source_select,
  input  wire logic                          loop_bypass_select,
  input  wire logic                          xtal_ref,
  input  wire logic                          alt_ref,
  input  wire logic                          osc_tick,
  // Loop outputs
  output logic                               ref_clk_sel,
  output logic                               mdiv_out,
  output logic                               osc_clk,
  // Synthesizer outputs
  output logic                               synth_out0_true,
  output logic                               synth_out0_comp,
  output logic                               synth_out1_true,
  output logic                               synth_out1_comp,
  output logic                               monitor_out,
  // Configuration status
  output sdc_pkg::sdc_cfg_t                  active_cfg
);
  import sdc_pkg::*;

  // --------------------------------------------------------------
  // Pin edge detection (inputs are synchronous to clk)
  // --------------------------------------------------------------
  logic                  pls_q;
  logic                  sclk_q;
  logic                  sld_q;
  logic                  sclk_rise;
  logic                  sld_rise;
  logic                  pls_rise;
  logic [WORD_WIDTH-1:0] shift_reg;
  logic [WORD_WIDTH-1:0] next_shift;
  sdc_cfg_t              cfg;
  sdc_cfg_t              next_cfg;
  sdc_mode_t             mode;
  logic [M_WIDTH-1:0]    mcnt;
  logic                  ref_now;
  logic                  ref_q;
  logic                  ref_rise;
  logic                  fout;

  // Previous pin levels for edge detection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pls_q  <= 1'b0;
      sclk_q <= 1'b0;
      sld_q  <= 1'b0;
    end else begin
      pls_q  <= parallel_load_strobe;
      sclk_q <= ser_clock;
      sld_q  <= ser_load;
    end
  end

  assign sclk_rise = ser_clock & ~sclk_q;
  assign sld_rise  = ser_load & ~sld_q;
  assign pls_rise  = parallel_load_strobe & ~pls_q;

  // --------------------------------------------------------------
  // Mode tracking
  // --------------------------------------------------------------
  // Serial mode sticks once a serial event lands while strobe high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= SDC_PAR;
    end else if (!parallel_load_strobe) begin
      mode <= SDC_PAR;
    end else if (ser_load) begin
      mode <= SDC_THRU;
    end else if (sclk_rise || mode == SDC_THRU) begin
      mode <= SDC_SER;
    end
  end

  // --------------------------------------------------------------
  // Shift register
  // --------------------------------------------------------------
  // MSB first: first bit shifted ends in the test field
  always_comb begin
    next_shift = shift_reg;
    if (parallel_load_strobe && sclk_rise) begin
      next_shift = {shift_reg[WORD_WIDTH-2:0], ser_data};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= WORD_RESET;
    end else begin
      shift_reg <= next_shift;
    end
  end

  // --------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------
  // The strobe rise outranks serial events; after it only serial events load
  always_comb begin
    next_cfg = cfg;
    if (!parallel_load_strobe) begin
      next_cfg.mdiv = feedback_div_in;
      next_cfg.ndiv = output_div_in;
    end else if (pls_rise) begin
      next_cfg.mdiv = feedback_div_in;
      next_cfg.ndiv = output_div_in;
    end else if (ser_load && (sld_rise || sclk_rise)) begin
      // Rise transfers; held high follows each shift
      next_cfg = sdc_cfg_t'(sld_rise ? shift_reg : next_shift);
    end
    // Load low: nothing changes, value frozen
  end

  // Master clear stops dividers and forces outputs, never this state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= '{tsel: T_RESET, ndiv: N_RESET, mdiv: M_RESET};
    end else begin
      cfg <= next_cfg;
    end
  end

  assign active_cfg = cfg;

  // --------------------------------------------------------------
  // Reference select and feedback divider
  // --------------------------------------------------------------
  // Crystal when high, alternate input when low
  assign ref_now = ref_source_select ? xtal_ref : alt_ref;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q       <= 1'b0;
      ref_clk_sel <= 1'b0;
    end else begin
      ref_q       <= ref_now;
      ref_clk_sel <= ref_now;
    end
  end

  assign ref_rise = ref_now & ~ref_q;

  // Counts oscillator ticks modulo M; pulse compared by loop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mcnt     <= '0;
      mdiv_out <= 1'b0;
    end else if (master_clear) begin
      mcnt     <= '0;
      mdiv_out <= 1'b0;
    end else if (osc_tick) begin
      if (mcnt >= cfg.mdiv - 9'h001) begin
        mcnt     <= '0;
        mdiv_out <= 1'b1;
      end else begin
        mcnt     <= mcnt + 9'h001;
        mdiv_out <= 1'b0;
      end
    end else begin
      mdiv_out <= 1'b0;
    end
  end

  // Bypass routes reference straight to the output divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_clk <= 1'b0;
    end else begin
      osc_clk <= loop_bypass_select ? ref_rise : osc_tick;
    end
  end

  // --------------------------------------------------------------
  // Output divider and differential outputs
  // --------------------------------------------------------------
  sdc_out_div u_out_div (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .hold_clear (master_clear),
    .ndiv       (cfg.ndiv),
    .osc_clk    (osc_clk),
    .div_out    (fout)
  );

  // Same divided signal to both pairs; clear forces true low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      synth_out0_true <= 1'b0;
      synth_out0_comp <= 1'b1;
      synth_out1_true <= 1'b0;
      synth_out1_comp <= 1'b1;
    end else begin
      synth_out0_true <= ~master_clear & fout;
      synth_out0_comp <= master_clear | ~fout;
      synth_out1_true <= ~master_clear & fout;
      synth_out1_comp <= master_clear | ~fout;
    end
  end

  // --------------------------------------------------------------
  // Monitor output
  // --------------------------------------------------------------
  // Low in parallel mode, until a serial event lands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_out <= 1'b0;
    end else if (!parallel_load_strobe || master_clear
                 || mode == SDC_PAR) begin
      monitor_out <= 1'b0;
    end else begin
      unique case (cfg.tsel)
        MON_LOW:   monitor_out <= 1'b0;
        MON_SDATA: monitor_out <= ser_data;
        MON_MDIV:  monitor_out <= mdiv_out;
        MON_FOUT:  monitor_out <= fout;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_par_thru;
    @(posedge clk) disable iff (sys_rst)
    !parallel_load_strobe |=> active_cfg.mdiv == $past(feedback_div_in);
  endproperty
  a_par_thru: assert property (p_par_thru)
    else $error("parallel pass-through lost");

  property p_mon_par;
    @(posedge clk) disable iff (sys_rst)
    !parallel_load_strobe |=> !monitor_out;
  endproperty
  a_mon_par: assert property (p_mon_par)
    else $error("monitor not low in parallel mode");

  property p_shift;
    @(posedge clk) disable iff (sys_rst)
    parallel_load_strobe && sclk_rise |=>
      shift_reg[0] == $past(ser_data);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted");

  property p_xfer;
    @(posedge clk) disable iff (sys_rst)
    parallel_load_strobe && !pls_rise && sld_rise |=>
      active_cfg == $past(shift_reg);
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("serial load did not transfer");

  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
    parallel_load_strobe && !ser_load && !pls_rise |=> $stable(active_cfg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("configuration moved while frozen");

  property p_clear_out;
    @(posedge clk) disable iff (sys_rst)
    master_clear |=> !synth_out0_true && synth_out0_comp
                     && !synth_out1_true && synth_out1_comp;
  endproperty
  a_clear_out: assert property (p_clear_out)
    else $error("outputs not cleared");

  property p_clear_keep;
    @(posedge clk) disable iff (sys_rst)
    master_clear && parallel_load_strobe && !ser_load && !pls_rise
      |=> $stable(active_cfg);
  endproperty
  a_clear_keep: assert property (p_clear_keep)
    else $error("clear disturbed configuration");

  property p_pair;
    @(posedge clk) disable iff (sys_rst)
    synth_out0_true == synth_out1_true
      && synth_out0_comp == ~synth_out0_true;
  endproperty
  a_pair: assert property (p_pair)
    else $error("output pairs disagree");

endmodule // sdc_config

// ### sdc_host_model.sv
`timescale 1ns/1ps
// Controller model: drives the programming pins at falling edges only
module sdc_host_model (
  // Clock
  input  wire logic                   clk,
  // Programming pins
  output logic                        parallel_load_strobe,
  output logic [sdc_pkg::M_WIDTH-1:0] feedback_div_in,
  output logic [sdc_pkg::N_WIDTH-1:0] output_div_in,
  output logic                        ser_clock,
  output logic                        ser_data,
  output logic                        ser_load
);
  import sdc_pkg::*;
  // Idle levels follow the pin pulls; strobe high keeps straps out
  initial begin
    parallel_load_strobe = 1'b1;
    feedback_div_in      = M_RESET;
    output_div_in        = N_RESET;
    {ser_clock, ser_data, ser_load} = 3'h0;
  end
  // Every level stands two clocks so the sampler cannot miss it
  task automatic hold2();
    repeat (2) @(negedge clk);
  endtask
  // Parallel pins together with the strobe level
  task automatic par(input logic [8:0] m, input logic [1:0] n,
                     input logic s);
    feedback_div_in      = m;
    output_div_in        = n;
    parallel_load_strobe = s;
    hold2();
  endtask
  // One bit: data set up with clock low, then clock high
  task automatic ser_bit(input logic b);
    ser_data  = b;
    ser_clock = 1'b0;
    hold2();
    ser_clock = 1'b1;
    hold2();
  endtask
  // Load level; clock parked low first to leave the null slot
  task automatic load(input logic l);
    ser_clock = 1'b0;
    ser_data  = 1'b0;
    hold2();
    ser_load = l;
    hold2();
  endtask
  // Data level with no clock edge
  task automatic sdata(input logic b);
    ser_data = b;
    hold2();
  endtask
endmodule // sdc_host_model

// ### sdc_out_div.sv
`timescale 1ns/1ps
// Output divider: power-of-two toggle divider, 50% duty at ratios 2, 4 and 8
module sdc_out_div (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Control
  input  wire logic                     hold_clear,
  input  wire logic [sdc_pkg::N_WIDTH-1:0] ndiv,
  input  wire logic                     osc_clk,
  // Output
  output logic                          div_out
);
  import sdc_pkg::*;

  logic [2:0] cnt;

  // --------------------------------------------------------------
  // Synchronous binary counter stepped by oscillator tick
  // --------------------------------------------------------------
  // Counter bits run at 1/2,1/4,1/8 of tick rate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 3'h0;
    end else if (hold_clear) begin
      cnt <= 3'h0;
    end else if (osc_clk) begin
      cnt <= cnt + 3'h1;
    end
  end

  // Output register; N=0 passes the tick, else counter bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_out <= 1'b0;
    end else if (hold_clear) begin
      div_out <= 1'b0;
    end else begin
      unique case (ndiv)
        2'h0: div_out <= osc_clk;
        2'h1: div_out <= cnt[0];
        2'h2: div_out <= cnt[1];
        2'h3: div_out <= cnt[2];
      endcase
    end
  end

endmodule // sdc_out_div

// ### sdc_pkg.sv
package sdc_pkg;

  // ----------------------------------------------------------------
  // Field widths and serial word layout
  // ----------------------------------------------------------------
  localparam int M_WIDTH    = 9;
  localparam int N_WIDTH    = 2;
  localparam int T_WIDTH    = 2;
  localparam int WORD_WIDTH = T_WIDTH + N_WIDTH + M_WIDTH;
  localparam int M_LSB      = 0;
  localparam int N_LSB      = M_WIDTH;
  localparam int T_LSB      = M_WIDTH + N_WIDTH;

  // ----------------------------------------------------------------
  // Reset values and decode constants
  // ----------------------------------------------------------------
  localparam logic [M_WIDTH-1:0]    M_RESET    = 9'h019;
  localparam logic [N_WIDTH-1:0]    N_RESET    = 2'h0;
  localparam logic [T_WIDTH-1:0]    T_RESET    = 2'h0;
  localparam logic [WORD_WIDTH-1:0] WORD_RESET = 13'h0000;
  localparam int                    NDIV_W     = 4;

  // Monitor select codes
  localparam logic [1:0] MON_LOW   = 2'h0;
  localparam logic [1:0] MON_SDATA = 2'h1;
  localparam logic [1:0] MON_MDIV  = 2'h2;
  localparam logic [1:0] MON_FOUT  = 2'h3;

  // ----------------------------------------------------------------
  // Carried configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [T_WIDTH-1:0] tsel;
    logic [N_WIDTH-1:0] ndiv;
    logic [M_WIDTH-1:0] mdiv;
  } sdc_cfg_t;

  typedef enum logic [2:0] {
    SDC_PAR  = 3'b001,
    SDC_SER  = 3'b010,
    SDC_THRU = 3'b100
  } sdc_mode_t;

  // Output divide ratio from the N field: 1, 2, 4, 8
  function automatic logic [NDIV_W-1:0] n_ratio(input logic [1:0] n);
    n_ratio = NDIV_W'(1) << n;
  endfunction

endpackage

// ### test_synth_divider_config_port.sv
`timescale 1ns/1ps
// Self-checking bench for the divider configuration port
module test_synth_divider_config_port;
  import sdc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0, sys_rst = 1'b1, master_clear = 1'b0;
  logic        ref_source_select = 1'b1, loop_bypass_select = 1'b0;
  logic        xtal_ref = 1'b0, alt_ref = 1'b0, osc_tick = 1'b0;
  logic        tick_en = 1'b1;
  logic        parallel_load_strobe, ser_clock, ser_data, ser_load;
  logic [M_WIDTH-1:0] feedback_div_in;
  logic [N_WIDTH-1:0] output_div_in;
  logic        ref_clk_sel, mdiv_out, osc_clk, monitor_out;
  logic        synth_out0_true, synth_out0_comp;
  logic        synth_out1_true, synth_out1_comp;
  sdc_cfg_t    active_cfg;
  wire  [4:0]  outs = {synth_out0_true, synth_out0_comp, synth_out1_true,
                       synth_out1_comp, monitor_out};
  int          err_count = 0, n_checks = 0, cyc = 0, sh = 0;
  logic [15:0] lf = 16'h0050;

  sdc_host_model u_host (.clk, .parallel_load_strobe, .feedback_div_in,
    .output_div_in, .ser_clock, .ser_data, .ser_load);
  sdc_config u_dut (.clk, .sys_rst, .parallel_load_strobe,
    .feedback_div_in, .output_div_in, .ser_clock, .ser_data, .ser_load,
    .master_clear, .ref_source_select, .loop_bypass_select, .xtal_ref,
    .alt_ref, .osc_tick, .ref_clk_sel, .mdiv_out, .osc_clk,
    .synth_out0_true, .synth_out0_comp, .synth_out1_true,
    .synth_out1_comp, .monitor_out, .active_cfg);

  // Clock and an oscillator model ticking every fourth cycle
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    cyc      <= cyc + 1;
    osc_tick <= tick_en && (cyc % 4 == 0);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  // Bits go out MSB first and are mirrored in the model register
  task automatic shift(input logic [12:0] w, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      u_host.ser_bit(w[i]);
      sh = ((sh << 1) | int'(w[i])) & 'h1FFF;
    end
  endtask
  // Count edges over a whole number of output and loop periods
  task automatic measure(input int k, input int m);
    int w = 32 * m;
    int r = 0, hi = 0, mp = 0, mh = 0, bad = 0;
    logic pv = synth_out0_true;
    int me;
    repeat (w) begin
      @(negedge clk);
      r   += int'(synth_out0_true === 1'b1 && pv === 1'b0);
      pv   = synth_out0_true;
      hi  += int'(synth_out0_true === 1'b1);
      mp  += int'(mdiv_out === 1'b1);
      mh  += int'(monitor_out === 1'b1);
      bad += int'({synth_out1_true, synth_out0_comp, synth_out1_comp}
             !== {synth_out0_true, ~synth_out0_true, ~synth_out0_true});
    end
    chk("out rises", r, (8 * m) >> k);
    if (k > 0) chk("out duty", hi, 16 * m);
    chk("mdiv pulses", mp, 8);
    chk("out pair", bad, 0);
    me = (k == 0) ? 0 : (k == 1) ? w : (k == 2) ? 8 : 16 * m;
    chk("monitor", mh, me);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    #250000;
    err_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int m;
    logic [12:0] w;
    logic e;
    repeat (2) @(negedge clk);
    chk("reset outs", outs, 5'h0A);
    sys_rst = 1'b0;
    settle();
    chk("reset cfg", active_cfg, {T_RESET, N_RESET, M_RESET});
    done("reset");
    // One serial word per monitor code, then rates are measured
    for (int k = 0; k < 4; k++) begin
      m = 25 + int'(rnd() % 7);
      w = {k[1:0], k[1:0], m[8:0]};
      shift(w, 13);
      u_host.load(1'b1);
      u_host.load(1'b0);
      chk("serial cfg", active_cfg, w);
      u_host.sdata(k == 1);
      repeat (64) @(negedge clk);
      measure(k, m);
      u_host.sdata(1'b0);
    end
    done("serial");
    // Pins pass straight through, monitor held low meanwhile
    for (int n = 0; n < 4; n++) begin
      m = 25 + int'(rnd() % 7);
      u_host.par(m[8:0], n[1:0], 1'b0);
      settle();
      chk("par cfg", active_cfg[10:0], {n[1:0], m[8:0]});
      chk("par monitor", monitor_out, 1'b0);
    end
    u_host.par(m[8:0], 2'h3, 1'b0);
    u_host.par(m[8:0], 2'h3, 1'b1);
    u_host.par(~m[8:0], 2'h0, 1'b1);
    settle();
    chk("par hold", active_cfg[10:0], {2'h3, m[8:0]});
    // Test bits untouched by the pins; monitor still parked
    chk("par tsel", active_cfg.tsel, 2'h3);
    chk("par hold monitor", monitor_out, 1'b0);
    done("parallel");
    // Load held high follows every shifted bit; low freezes
    u_host.load(1'b1);
    settle();
    chk("follow start", active_cfg, sh[12:0]);
    for (int i = 0; i < 13; i++) begin
      shift(13'(rnd()), 1);
      settle();
      chk("follow bit", active_cfg, sh[12:0]);
    end
    u_host.load(1'b0);
    w = sh[12:0];
    shift(13'(rnd()), 5);
    settle();
    chk("frozen", active_cfg, w);
    done("follow");
    // Master clear forces outputs but keeps the configuration
    master_clear = 1'b1;
    repeat (8) @(negedge clk);
    chk("clear outs", outs, 5'h0A);
    chk("clear cfg", active_cfg, w);
    master_clear = 1'b0;
    done("clear");
    // Reference source choice
    repeat (8) begin
      {ref_source_select, xtal_ref, alt_ref} = 3'(rnd());
      settle();
      e = ref_source_select ? xtal_ref : alt_ref;
      chk("ref sel", ref_clk_sel, e);
    end
    // Bypass: reference rises alone pace the oscillator output
    {tick_en, loop_bypass_select, ref_source_select, xtal_ref} = 4'h6;
    settle();
    m = 0;
    for (int i = 0; i < 40; i++) begin
      xtal_ref = (i < 32) && (i % 4 >= 2);
      @(negedge clk);
      m += int'(osc_clk === 1'b1);
    end
    chk("bypass pulses", m, 8);
    done("bypass");
    complete_run();
  end
endmodule // test_synth_divider_config_port
